// ==== bgc_pkg.sv ====
// Functional notes
// - Prefetch off clear: fetch to cache line
// - Prefetch off set: fetch one doubleword only
// - Prefetch off set: fourfold prefetch ignored
// - Prefetch off acts only with line check
// - Standby latency 18:16 mirrored to caps 8:6
// - Standby code 000 lowest, 111 above 4us
// - Sleep latency 15:13 mirrored to caps 11:9
// - Sleep code 000 lowest, 111 above 64us
// - Virtual channel enable bit reads zero
// - VC enable picks AER next offset 000h/150h
// - Clock stop clear: secondary clocks run in D3
// - Clock stop set: secondary clocks stop in D3
// - Bit 10: wake only, or beacon plus wake
// - Fundamental reset clears all but wake bit
// - Wake bit cleared by global or power-on reset
`default_nettype none

package bgc_pkg;

  // ----------------------------------------------------------------
  // Bus layout
  // ----------------------------------------------------------------
  localparam int         BGC_ADDR_W      = 8;
  localparam int         BGC_DATA_W      = 32;
  localparam logic [7:0] BGC_OFS_CTRL    = 8'h00;
  localparam logic [7:0] BGC_OFS_DEVCAP  = 8'h04;
  localparam logic [7:0] BGC_OFS_AER     = 8'h08;
  localparam logic [7:0] BGC_OFS_STAT    = 8'h0C;
  localparam logic [1:0] BGC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] BGC_RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int BGC_LAT_W          = 3;
  localparam int BGC_BIT_PREF_OFF   = 19;
  localparam int BGC_LSB_STANDBY    = 16;
  localparam int BGC_LSB_SLEEP      = 13;
  localparam int BGC_BIT_VC         = 12;
  localparam int BGC_BIT_CLK_STOP   = 11;
  localparam int BGC_BIT_BEACON     = 10;

  // ----------------------------------------------------------------
  // Mirrored fields
  // ----------------------------------------------------------------
  localparam int BGC_LSB_CAP_STANDBY = 6;
  localparam int BGC_LSB_CAP_SLEEP   = 9;
  localparam int BGC_AER_W           = 12;
  localparam int BGC_LSB_AER_NEXT    = 20;
  localparam logic [11:0] BGC_AER_NEXT_OFF = 12'h000;
  localparam logic [11:0] BGC_AER_NEXT_ON  = 12'h150;

  // ----------------------------------------------------------------
  // Status word bits
  // ----------------------------------------------------------------
  localparam int BGC_ST_LINE     = 0;
  localparam int BGC_ST_SINGLE   = 1;
  localparam int BGC_ST_FOURFOLD = 2;
  localparam int BGC_ST_CLK_RUN  = 3;
  localparam int BGC_ST_BEACON   = 4;
  localparam int BGC_ST_WAKE     = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] BGC_RST_LAT      = 3'h0;
  localparam logic       BGC_RST_PREF_OFF = 1'b0;
  localparam logic       BGC_RST_CLK_STOP = 1'b0;
  localparam logic       BGC_RST_BEACON   = 1'b0;
  localparam logic       BGC_VC_CAP_ON    = 1'b0;

endpackage

`default_nettype wire

// ==== bgc_reset_gen.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Reset domains for the control fields
// ------------------------------------------------------------------
module bgc_reset_gen (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pcie_reset_n,
  input  wire logic global_reset_n,
  output var  logic fundamental_reset,
  output var  logic global_reset
);

  // Power-on reset is aresetn; both domains held during it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fundamental_reset <= 1'b1;
      global_reset      <= 1'b1;
    end else begin
      fundamental_reset <= !pcie_reset_n || !global_reset_n;
      global_reset      <= !global_reset_n;
    end
  end

endmodule

`default_nettype wire

// ==== bgc_ctrl.sv ====
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module bgc_ctrl (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic                             pcie_reset_n,
  input  wire logic                             global_reset_n,
  input  wire logic [bgc_pkg::BGC_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                       s_axi_awprot,
  input  wire logic                             s_axi_awvalid,
  output var  logic                             s_axi_awready,
  input  wire logic [bgc_pkg::BGC_DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output var  logic                             s_axi_wready,
  output var  logic [1:0]                       s_axi_bresp,
  output var  logic                             s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [bgc_pkg::BGC_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                       s_axi_arprot,
  input  wire logic                             s_axi_arvalid,
  output var  logic                             s_axi_arready,
  output var  logic [bgc_pkg::BGC_DATA_W-1:0]   s_axi_rdata,
  output var  logic [1:0]                       s_axi_rresp,
  output var  logic                             s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  input  wire logic                             cache_line_check_on,
  input  wire logic                             fourfold_prefetch,
  input  wire logic                             d3_state,
  output var  logic                             prefetch_to_line,
  output var  logic                             prefetch_single_dword,
  output var  logic                             prefetch_fourfold,
  output var  logic                             secondary_clk_run,
  output var  logic                             wake_use_beacon,
  output var  logic                             wake_use_signal,
  output var  logic [bgc_pkg::BGC_LAT_W-1:0]    cap_standby_exit_latency,
  output var  logic [bgc_pkg::BGC_LAT_W-1:0]    cap_sleep_exit_latency,
  output var  logic [bgc_pkg::BGC_AER_W-1:0]    aer_next_offset
);
  import bgc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                  fundamental_reset;
  logic                  global_reset;
  logic                  read_prefetch_off;
  logic [BGC_LAT_W-1:0]  standby_exit_latency_code;
  logic [BGC_LAT_W-1:0]  sleep_exit_latency_code;
  logic                  d3_secondary_clock_stop;
  logic                  wake_beacon_on;
  logic                  aw_held;
  logic                  w_held;
  logic [BGC_ADDR_W-1:0] aw_addr_q;
  logic [BGC_DATA_W-1:0] w_data_q;
  logic [3:0]            w_strb_q;
  logic                  aw_take;
  logic                  w_take;
  logic                  ar_take;
  logic                  do_write;
  logic                  next_aw_held;
  logic                  next_w_held;
  logic                  wr_hit_ctrl;
  logic                  wr_mapped;
  logic [BGC_DATA_W-1:0] ctrl_word;
  logic [BGC_DATA_W-1:0] devcap_word;
  logic [BGC_DATA_W-1:0] aer_word;
  logic [BGC_DATA_W-1:0] stat_word;
  logic [BGC_DATA_W-1:0] rd_word;
  logic                  rd_mapped;
  logic [BGC_AER_W-1:0]  next_aer_offset;

  bgc_reset_gen u_reset_gen (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .pcie_reset_n      (pcie_reset_n),
    .global_reset_n    (global_reset_n),
    .fundamental_reset (fundamental_reset),
    .global_reset      (global_reset)
  );

  // ----------------------------------------------------------------
  // Write channel handshake
  // ----------------------------------------------------------------
  assign aw_take  = s_axi_awvalid && s_axi_awready;
  assign w_take   = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_comb begin
    next_aw_held = (aw_held || aw_take) && !do_write;
    next_w_held  = (w_held || w_take) && !do_write;
  end

  // Address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      s_axi_awready <= !next_aw_held;
      s_axi_wready  <= !next_w_held;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  always_comb begin
    wr_hit_ctrl = aw_addr_q[BGC_ADDR_W-1:2] == BGC_OFS_CTRL[7:2];
    wr_mapped   = wr_hit_ctrl
               || aw_addr_q[BGC_ADDR_W-1:2] == BGC_OFS_DEVCAP[7:2]
               || aw_addr_q[BGC_ADDR_W-1:2] == BGC_OFS_AER[7:2]
               || aw_addr_q[BGC_ADDR_W-1:2] == BGC_OFS_STAT[7:2];
  end

  // Read-only words accept writes with OKAY and keep their value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= BGC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? BGC_RESP_OKAY : BGC_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Fields under fundamental reset
  // ----------------------------------------------------------------
  // Reset wins over a write landing in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || fundamental_reset) begin
      read_prefetch_off         <= BGC_RST_PREF_OFF;
      standby_exit_latency_code <= BGC_RST_LAT;
      sleep_exit_latency_code   <= BGC_RST_LAT;
      d3_secondary_clock_stop   <= BGC_RST_CLK_STOP;
    end else if (do_write && wr_hit_ctrl) begin
      if (w_strb_q[2]) begin
        read_prefetch_off <= w_data_q[BGC_BIT_PREF_OFF];
        standby_exit_latency_code <=
          w_data_q[BGC_LSB_STANDBY +: BGC_LAT_W];
      end
      if (w_strb_q[1]) begin
        sleep_exit_latency_code <=
          w_data_q[BGC_LSB_SLEEP +: BGC_LAT_W];
        d3_secondary_clock_stop <= w_data_q[BGC_BIT_CLK_STOP];
      end
    end
  end

  // ----------------------------------------------------------------
  // Wake select under global or power-on reset
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || global_reset) begin
      wake_beacon_on <= BGC_RST_BEACON;
    end else if (do_write && wr_hit_ctrl && w_strb_q[1]) begin
      wake_beacon_on <= w_data_q[BGC_BIT_BEACON];
    end
  end

  // ----------------------------------------------------------------
  // Block outputs
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prefetch_to_line      <= 1'b1;
      prefetch_single_dword <= 1'b0;
      prefetch_fourfold     <= 1'b0;
    end else if (cache_line_check_on && read_prefetch_off) begin
      prefetch_to_line      <= 1'b0;
      prefetch_single_dword <= 1'b1;
      prefetch_fourfold     <= 1'b0;
    end else begin
      // Without line check the bit is inert, as if clear
      prefetch_to_line      <= 1'b1;
      prefetch_single_dword <= 1'b0;
      prefetch_fourfold     <= fourfold_prefetch;
    end
  end

  // Stopping relies on the host keeping refclk when clocks must run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      secondary_clk_run <= 1'b1;
    end else begin
      secondary_clk_run <=
        !(d3_state && d3_secondary_clock_stop);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_use_beacon <= BGC_RST_BEACON;
      wake_use_signal <= 1'b1;
    end else begin
      wake_use_beacon <= wake_beacon_on;
      wake_use_signal <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_standby_exit_latency <= BGC_RST_LAT;
      cap_sleep_exit_latency   <= BGC_RST_LAT;
    end else begin
      cap_standby_exit_latency <= standby_exit_latency_code;
      cap_sleep_exit_latency   <= sleep_exit_latency_code;
    end
  end

  assign next_aer_offset = BGC_VC_CAP_ON ? BGC_AER_NEXT_ON
                                         : BGC_AER_NEXT_OFF;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aer_next_offset <= BGC_AER_NEXT_OFF;
    end else begin
      aer_next_offset <= next_aer_offset;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_word = '0;
    ctrl_word[BGC_BIT_PREF_OFF] = read_prefetch_off;
    ctrl_word[BGC_LSB_STANDBY +: BGC_LAT_W] = standby_exit_latency_code;
    ctrl_word[BGC_LSB_SLEEP +: BGC_LAT_W] = sleep_exit_latency_code;
    ctrl_word[BGC_BIT_VC] = BGC_VC_CAP_ON;
    ctrl_word[BGC_BIT_CLK_STOP] = d3_secondary_clock_stop;
    ctrl_word[BGC_BIT_BEACON] = wake_beacon_on;
    devcap_word = '0;
    devcap_word[BGC_LSB_CAP_STANDBY +: BGC_LAT_W] = cap_standby_exit_latency;
    devcap_word[BGC_LSB_CAP_SLEEP +: BGC_LAT_W] = cap_sleep_exit_latency;
    aer_word = '0;
    aer_word[BGC_LSB_AER_NEXT +: BGC_AER_W] = aer_next_offset;
    stat_word = '0;
    stat_word[BGC_ST_LINE] = prefetch_to_line;
    stat_word[BGC_ST_SINGLE] = prefetch_single_dword;
    stat_word[BGC_ST_FOURFOLD] = prefetch_fourfold;
    stat_word[BGC_ST_CLK_RUN] = secondary_clk_run;
    stat_word[BGC_ST_BEACON] = wake_use_beacon;
    stat_word[BGC_ST_WAKE] = wake_use_signal;
    rd_mapped = 1'b1;
    case (s_axi_araddr[BGC_ADDR_W-1:2])
      BGC_OFS_CTRL[7:2]: begin
        rd_word = ctrl_word;
      end
      BGC_OFS_DEVCAP[7:2]: begin
        rd_word = devcap_word;
      end
      BGC_OFS_AER[7:2]: begin
        rd_word = aer_word;
      end
      BGC_OFS_STAT[7:2]: begin
        rd_word = stat_word;
      end
      default: begin
        rd_word   = '0;
        rd_mapped = 1'b0;
      end
    endcase
  end

  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= BGC_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_mapped ? BGC_RESP_OKAY : BGC_RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_line_prefetch;
    @(posedge aclk) disable iff (!aresetn)
    cache_line_check_on && !read_prefetch_off
      |=> prefetch_to_line && !prefetch_single_dword;
  endproperty
  a_line_prefetch: assert property (p_line_prefetch)
    else $error("line prefetch not selected");

  property p_single_dword;
    @(posedge aclk) disable iff (!aresetn)
    cache_line_check_on && read_prefetch_off
      |=> prefetch_single_dword && !prefetch_to_line;
  endproperty
  a_single_dword: assert property (p_single_dword)
    else $error("single dword fetch not selected");

  property p_fourfold_ignored;
    @(posedge aclk) disable iff (!aresetn)
    cache_line_check_on && read_prefetch_off && fourfold_prefetch
      |=> !prefetch_fourfold;
  endproperty
  a_fourfold_ignored: assert property (p_fourfold_ignored)
    else $error("fourfold prefetch not suppressed");

  property p_check_gate;
    @(posedge aclk) disable iff (!aresetn)
    !cache_line_check_on
      |=> prefetch_to_line && prefetch_fourfold == $past(fourfold_prefetch);
  endproperty
  a_check_gate: assert property (p_check_gate)
    else $error("prefetch off acted without line check");

  property p_cap_standby;
    @(posedge aclk) disable iff (!aresetn)
    do_write && wr_hit_ctrl && w_strb_q[2] && !fundamental_reset
      |-> ##2 cap_standby_exit_latency
          == $past(w_data_q[BGC_LSB_STANDBY +: BGC_LAT_W], 2);
  endproperty
  a_cap_standby: assert property (p_cap_standby)
    else $error("standby latency not mirrored");

  property p_cap_sleep;
    @(posedge aclk) disable iff (!aresetn)
    do_write && wr_hit_ctrl && w_strb_q[1] && !fundamental_reset
      |-> ##2 cap_sleep_exit_latency
          == $past(w_data_q[BGC_LSB_SLEEP +: BGC_LAT_W], 2);
  endproperty
  a_cap_sleep: assert property (p_cap_sleep)
    else $error("sleep latency not mirrored");

  property p_vc_reads_zero;
    @(posedge aclk) disable iff (!aresetn)
    ar_take && s_axi_araddr[BGC_ADDR_W-1:2] == BGC_OFS_CTRL[7:2]
      |=> s_axi_rvalid && !s_axi_rdata[BGC_BIT_VC];
  endproperty
  a_vc_reads_zero: assert property (p_vc_reads_zero)
    else $error("virtual channel bit read as one");

  property p_aer_offset;
    @(posedge aclk) disable iff (!aresetn)
    ##1 aer_next_offset == BGC_AER_NEXT_OFF;
  endproperty
  a_aer_offset: assert property (p_aer_offset)
    else $error("AER next offset wrong");

  property p_clk_stop;
    @(posedge aclk) disable iff (!aresetn)
    d3_state && d3_secondary_clock_stop |=> !secondary_clk_run;
  endproperty
  a_clk_stop: assert property (p_clk_stop)
    else $error("secondary clocks not stopped in D3");

  property p_clk_keep;
    @(posedge aclk) disable iff (!aresetn)
    !d3_secondary_clock_stop |=> secondary_clk_run;
  endproperty
  a_clk_keep: assert property (p_clk_keep)
    else $error("secondary clocks stopped while allowed to run");

  property p_wake_select;
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> wake_use_signal && wake_use_beacon == $past(wake_beacon_on);
  endproperty
  a_wake_select: assert property (p_wake_select)
    else $error("wake mechanism select wrong");

  property p_fund_clear;
    @(posedge aclk) disable iff (!aresetn)
    fundamental_reset |=> !read_prefetch_off && !d3_secondary_clock_stop
      && standby_exit_latency_code == BGC_RST_LAT
      && sleep_exit_latency_code == BGC_RST_LAT;
  endproperty
  a_fund_clear: assert property (p_fund_clear)
    else $error("fundamental reset left a field set");

  property p_wake_survives;
    @(posedge aclk) disable iff (!aresetn)
    fundamental_reset && !global_reset
      && !(do_write && wr_hit_ctrl && w_strb_q[1])
      |=> $stable(wake_beacon_on);
  endproperty
  a_wake_survives: assert property (p_wake_survives)
    else $error("wake select lost without global reset");

  property p_write_resp;
    @(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write response missing");

endmodule

`default_nettype wire

// ==== bgc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Host side: control register bits and resets
// ------------------------------------------------------------------
module bgc_host_model (
  input  wire logic       aclk,
  input  wire logic [4:0] req,
  output var  logic       cache_line_check_on,
  output var  logic       fourfold_prefetch,
  output var  logic       d3_state,
  output var  logic       pcie_reset_n,
  output var  logic       global_reset_n
);
  // Idle levels so the design sees no unknowns before the first edge
  initial begin
    {cache_line_check_on, fourfold_prefetch, d3_state} = 3'h0;
    {pcie_reset_n, global_reset_n} = 2'h3;
  end
  always @(posedge aclk) begin
    cache_line_check_on <= req[0];
    fourfold_prefetch   <= req[1];
    d3_state            <= req[2];
    pcie_reset_n        <= !req[3];
    global_reset_n      <= !req[4];
  end
endmodule

`default_nettype wire

// ==== bridge_general_control_fields_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module bridge_general_control_fields_test;
  import bgc_pkg::*;
  localparam logic [31:0] WMASK = 32'h000FEC00;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [4:0]  req = 5'h00;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [31:0] lfsr = 32'h0001159A;
  logic [31:0] cur, rdat;
  logic [1:0]  resp;
  int          num_errors = 0, compares = 0;
  wire logic   pcie_reset_n, global_reset_n, cache_line_check_on;
  wire logic   fourfold_prefetch, d3_state, s_axi_awready, s_axi_wready;
  wire logic   s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic   prefetch_to_line, prefetch_single_dword, prefetch_fourfold;
  wire logic   secondary_clk_run, wake_use_beacon, wake_use_signal;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [2:0]  cap_standby_exit_latency, cap_sleep_exit_latency;
  wire logic [11:0] aer_next_offset;

  // Reference clock always runs, the host never stops it
  always #20 aclk = !aclk;

  bgc_host_model host (.aclk, .req, .cache_line_check_on,
    .fourfold_prefetch, .d3_state, .pcie_reset_n, .global_reset_n);

  bgc_ctrl DUT (.aclk, .aresetn, .pcie_reset_n, .global_reset_n,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cache_line_check_on,
    .fourfold_prefetch, .d3_state, .prefetch_to_line,
    .prefetch_single_dword, .prefetch_fourfold, .secondary_clk_run,
    .wake_use_beacon, .wake_use_signal, .cap_standby_exit_latency,
    .cap_sleep_exit_latency, .aer_next_offset);

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] exp_stat(input logic [4:0] q,
                                           input logic [31:0] c);
    logic off;
    off = q[0] && c[19];
    return {26'h0, 1'b1, c[10], !(q[2] && c[11]), !off && q[1], off, !off};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic ad, wd;
    int n;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(ad && wd && s_axi_bvalid === 1'b1) && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 100) chk(32'h0, 32'h1, "write hang");
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) chk(32'h0, 32'h1, "read hang");
    @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // Ports and readback against the expected control word
  // ----------------------------------------------------------------
  task automatic check_all(input logic [31:0] c);
    repeat (3) @(posedge aclk);
    chk({26'h0, wake_use_signal, wake_use_beacon, secondary_clk_run,
         prefetch_fourfold, prefetch_single_dword, prefetch_to_line},
        exp_stat(req, c), "outputs");
    chk({26'h0, cap_sleep_exit_latency, cap_standby_exit_latency},
        {26'h0, c[15:13], c[18:16]}, "caps");
    chk({20'h0, aer_next_offset}, 32'h0, "aer port");
    rd(BGC_OFS_CTRL, rdat, resp);
    chk(rdat, c, "ctrl");
    rd(BGC_OFS_DEVCAP, rdat, resp);
    chk(rdat, {20'h0, c[15:13], c[18:16], 6'h0}, "devcap");
    rd(BGC_OFS_AER, rdat, resp);
    chk(rdat, {BGC_AER_NEXT_OFF, 20'h0}, "aer reg");
    rd(BGC_OFS_STAT, rdat, resp);
    chk(rdat, exp_stat(req, c), "status");
    chk({30'h0, resp}, {30'h0, BGC_RESP_OKAY}, "rresp");
  endtask

  task automatic close_out();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check_all(32'h0);
    // Random words and host bits, then every host combination at max codes
    for (int i = 0; i < 40; i++) begin
      lfsr = nxt(lfsr);
      req <= (i >= 32) ? {2'h0, 3'(i)} : {2'h0, lfsr[31:29]};
      cur = (i >= 32) ? 32'hFFFFFFFF : lfsr;
      wr(BGC_OFS_CTRL, cur, 4'hF, resp);
      chk({30'h0, resp}, {30'h0, BGC_RESP_OKAY}, "bresp");
      cur = cur & WMASK;
      check_all(cur);
    end
    // Lane strobes gate their own bit groups
    wr(BGC_OFS_CTRL, 32'h0, 4'h2, resp);
    cur = cur & ~32'h0000FC00;
    check_all(cur);
    wr(BGC_OFS_CTRL, 32'hFFFFFFFF, 4'hB, resp);
    cur = cur | 32'h0000EC00;
    check_all(cur);
    wr(BGC_OFS_DEVCAP, 32'hFFFFFFFF, 4'hF, resp);
    check_all(cur);
    wr(8'h10, 32'hFFFFFFFF, 4'hF, resp);
    chk({30'h0, resp}, {30'h0, BGC_RESP_DECERR}, "unmapped wr");
    rd(8'h10, rdat, resp);
    chk(rdat, 32'h0, "unmapped rd");
    chk({30'h0, resp}, {30'h0, BGC_RESP_DECERR}, "unmapped rresp");
    // Link reset keeps the wake bit, global reset clears it
    wr(BGC_OFS_CTRL, 32'hFFFFFFFF, 4'hF, resp);
    req <= 5'h08;
    repeat (4) @(posedge aclk);
    req <= 5'h00;
    check_all(32'h00000400);
    req <= 5'h10;
    repeat (4) @(posedge aclk);
    req <= 5'h00;
    check_all(32'h0);
    close_out();
  end
endmodule

`default_nettype wire
